/* hdl/page_history_recorder.sv */
// Purpose: Keeps referenced and changed page flags in the page table and cache.
// Assumes: One access offered at a time; memory sets mask bits without clearing others.
// Notes:   Registers on AXI4-Lite; flag updates are single set-only writes.
// Operation
// - Record history only for paged translation, never for block translation.
// - Record history only when instruction or data translation is enabled.
// - Flags 00: read sets referenced, write sets both.
// - Flags 10: read does nothing, write sets changed.
// - Flags 11: no page table update at all.
// - On cache hit, referenced assumed set; changed judged from cached copy.
// - Touch hints may set referenced but never changed.
// - Flag updates are made as real, untranslated accesses.
// - Every fetch, read or write reference sets the referenced flag.
// - Referenced may be set at start or after the access succeeds.
// - The referenced flag is never cleared by hardware.
// - Referenced may be set by accesses not logically needed.
// - Store hit with changed clear sets cache copy and table entry.
// - Changed set only for permitted stores certain to execute.
// - Changed may also be set by no-op conditional, zero string store, invalidate.
// - No other event sets the changed flag.
// - Flag positions are bits 55/56 or 23/24 by entry format.
// - Updates use storage attributes 0010, physical access.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module page_history_recorder
  import rc_history_pkg::*;
#(
  parameter int PA_W = 48
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              acc_valid,
  output logic                   acc_ready,
  input  wire logic [2:0]        acc_kind,
  input  wire logic              acc_block_xlate,
  input  wire logic              instr_translate_enable,
  input  wire logic              data_translate_enable,
  input  wire logic              acc_cache_hit,
  input  wire logic              acc_cur_r,
  input  wire logic              acc_cur_c,
  input  wire logic              acc_prot_ok,
  input  wire logic              acc_in_path,
  input  wire logic              acc_precise_exc,
  input  wire logic              acc_done_ok,
  input  wire logic [PA_W-1:0]   acc_pte_addr,
  output logic                   cache_set_r,
  output logic                   cache_set_c,
  output logic                   mem_req_valid,
  input  wire logic              mem_req_ready,
  output logic [PA_W-1:0]        mem_req_addr,
  output logic [63:0]            mem_req_set_mask,
  output logic [ATTR_W-1:0]      mem_req_attr,
  output logic                   mem_req_real,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  hist_decide_if     dif ();
  upd_state_t        state_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [31:0]       count_r;
  logic [4:0]        last_r;
  logic              acc_fire;
  logic              upd_need;
  logic              mem_fire;
  logic [5:0]        r_idx;
  logic [5:0]        c_idx;
  logic [63:0]       mask_nxt;
  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic              w_strb0_r;
  logic              wr_go;
  logic              rd_go;
  logic [31:0]       rd_data_nxt;
  logic [1:0]        rd_resp_nxt;

  // Presents the offered access to the flag decider.
  assign dif.kind        = access_kind_t'(acc_kind);
  assign dif.blk         = acc_block_xlate;
  assign dif.ir          = instr_translate_enable;
  assign dif.dr          = data_translate_enable;
  assign dif.hit         = acc_cache_hit;
  assign dif.cur_r       = acc_cur_r;
  assign dif.cur_c       = acc_cur_c;
  assign dif.prot_ok     = acc_prot_ok;
  assign dif.in_path     = acc_in_path;
  assign dif.precise_exc = acc_precise_exc;
  assign dif.done_ok     = acc_done_ok;
  assign dif.ctrl        = ctrl_r;

  hist_decide u_decide (
    .d (dif.dec)
  );

  // Handshake terms and the set-only update mask for the chosen entry format.
  assign acc_fire = acc_valid && acc_ready;
  assign upd_need = dif.need_r || dif.need_c;
  assign mem_fire = mem_req_valid && mem_req_ready;
  assign r_idx    = flag_idx(ctrl_r[CTRL_FMT64], ctrl_r[CTRL_FMT64] ? R_POS64 : R_POS32);
  assign c_idx    = flag_idx(ctrl_r[CTRL_FMT64], ctrl_r[CTRL_FMT64] ? C_POS64 : C_POS32);

  // Builds the mask; only set bits are ever sent, so no flag is cleared.
  always_comb begin
    mask_nxt = '0;
    mask_nxt[r_idx] = dif.need_r;
    mask_nxt[c_idx] = dif.need_c;
  end

  // Update sequencer: idle until an access needs a table write, then issue it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      acc_ready <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (acc_fire && upd_need) begin
            state_r   <= ST_ISSUE;
            acc_ready <= 1'b0;
          end
        end
        ST_ISSUE: begin
          if (mem_fire) begin
            state_r   <= ST_IDLE;
            acc_ready <= 1'b1;
          end
        end
        default: begin
          state_r   <= ST_IDLE;
          acc_ready <= 1'b1;
        end
      endcase
    end
  end

  // Table write request: held until memory takes it, always as real access.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_req_valid    <= 1'b0;
      mem_req_addr     <= '0;
      mem_req_set_mask <= '0;
      mem_req_attr     <= ATTR_PTE;
      mem_req_real     <= 1'b1;
    end else if (acc_fire && upd_need) begin
      mem_req_valid    <= 1'b1;
      mem_req_addr     <= acc_pte_addr;
      mem_req_set_mask <= mask_nxt;
      mem_req_attr     <= ATTR_PTE;
      mem_req_real     <= 1'b1;
    end else if (mem_fire) begin
      mem_req_valid    <= 1'b0;
    end
  end

  // One-cycle pulses that set the flags in the translation cache entry.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cache_set_r <= 1'b0;
      cache_set_c <= 1'b0;
    end else begin
      cache_set_r <= acc_fire && dif.need_r;
      cache_set_c <= acc_fire && dif.need_c;
    end
  end

  // Counts table writes and remembers the last update for software.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_r <= '0;
      last_r  <= '0;
    end else begin
      if (mem_fire) begin
        count_r <= count_r + 32'h0000_0001;
      end
      if (acc_fire && upd_need) begin
        last_r <= {acc_kind, dif.need_c, dif.need_r};
      end
    end
  end

  // AXI write address and data are caught independently, in either order.
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Register write and its response; unmapped addresses answer DECERR.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r       <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OKAY;
      case (aw_addr_r)
        REG_CTRL: begin
          if (w_strb0_r) begin
            ctrl_r <= w_data_r[CTRL_W-1:0];
          end
        end
        REG_STATUS, REG_COUNT, REG_LAST: begin
          s_axi_bresp <= RESP_OKAY;
        end
        default: s_axi_bresp <= RESP_DECERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data selection.
  always_comb begin
    rd_data_nxt = '0;
    rd_resp_nxt = RESP_OKAY;
    case (s_axi_araddr)
      REG_CTRL:   rd_data_nxt[CTRL_W-1:0] = ctrl_r;
      REG_STATUS: rd_data_nxt[0] = (state_r == ST_ISSUE);
      REG_COUNT:  rd_data_nxt = count_r;
      REG_LAST:   rd_data_nxt[4:0] = last_r;
      default:    rd_resp_nxt = RESP_DECERR;
    endcase
  end

  // Read channel: address taken when no answer is pending, data one cycle later.
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data_nxt;
        s_axi_rresp  <= rd_resp_nxt;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  chk_block_no_update: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && acc_block_xlate |=> !mem_req_valid && !cache_set_r && !cache_set_c)
    else $error("Block-translated access caused a flag update.");

  chk_xlate_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && !instr_translate_enable && !data_translate_enable |=> !mem_req_valid)
    else $error("Flag update issued with translation disabled.");

  chk_both_flags_once: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && acc_kind == K_STORE && !acc_cache_hit && !acc_cur_r && !acc_cur_c
    && ctrl_r[CTRL_EN] && acc_prot_ok && acc_in_path && !acc_precise_exc && !acc_block_xlate
    && data_translate_enable
    |=> mem_req_valid && mem_req_set_mask[r_idx] && mem_req_set_mask[c_idx])
    else $error("Store on clean page did not set both flags in one update.");

  chk_flags_set_quiet: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && acc_cur_r && acc_cur_c |=> !mem_req_valid && !cache_set_r && !cache_set_c)
    else $error("Page with both flags set caused a table update.");

  chk_touch_no_change: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && (acc_kind == K_TOUCH || acc_kind == K_TOUCH_ST) |=> !cache_set_c
    && !(mem_req_valid && mem_req_set_mask[c_idx]))
    else $error("Touch hint set the changed flag.");

  chk_real_attr: assert property (@(posedge core_clk) disable iff (rst)
    mem_req_valid |-> mem_req_real && mem_req_attr == ATTR_PTE)
    else $error("Flag update not issued as real access with attributes 0010.");

  chk_req_held: assert property (@(posedge core_clk) disable iff (rst)
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_set_mask)
    && $stable(mem_req_addr))
    else $error("Table update request dropped or changed before it was taken.");

  chk_count_step: assert property (@(posedge core_clk) disable iff (rst)
    mem_fire |=> count_r == $past(count_r) + 32'h0000_0001 && acc_ready)
    else $error("Update count or ready did not follow a taken update.");

  chk_store_hit_c: assert property (@(posedge core_clk) disable iff (rst)
    acc_fire && acc_kind == K_STORE && acc_cache_hit && !acc_cur_c && ctrl_r[CTRL_EN]
    && acc_prot_ok && acc_in_path && !acc_precise_exc && !acc_block_xlate
    && data_translate_enable |=> cache_set_c && !cache_set_r && mem_req_valid)
    else $error("Store hit with changed clear did not set changed only.");

  chk_mask_only_flags: assert property (@(posedge core_clk) disable iff (rst)
    mem_req_valid |-> (mem_req_set_mask & ~((64'h1 << r_idx) | (64'h1 << c_idx))) == '0)
    else $error("Update mask touches bits other than the history flags.");
endmodule

/* hdl/rc_history_pkg.sv */
// Purpose: Shared constants and types for the page history recorder.
// Assumes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
// Notes:   Flag positions are given in big-endian bit numbering.
package rc_history_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_COUNT   = 8'h08;
  localparam logic [7:0]  REG_LAST    = 8'h0C;
  localparam int          CTRL_W      = 5;
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_FMT64  = 1;
  localparam int          CTRL_DEFER  = 2;
  localparam int          CTRL_OPT_C  = 3;
  localparam int          CTRL_TOUCH  = 4;
  localparam logic [4:0]  CTRL_RST    = 5'h13;
  localparam int          R_POS64     = 55;
  localparam int          C_POS64     = 56;
  localparam int          R_POS32     = 23;
  localparam int          C_POS32     = 24;
  localparam int          DW_MSB      = 63;
  localparam int          W_MSB       = 31;
  localparam int          ATTR_W      = 4;
  localparam logic [3:0]  ATTR_PTE    = 4'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    K_FETCH, K_LOAD, K_STORE, K_TOUCH, K_TOUCH_ST, K_CSTORE_NOP, K_STR_ZERO, K_BLK_INVAL
  } access_kind_t;

  typedef enum logic [0:0] {ST_IDLE, ST_ISSUE} upd_state_t;

  // Turns a big-endian flag position into a little-endian index of the update mask.
  function automatic logic [5:0] flag_idx(input logic fmt64, input int pos);
    int idx;
    idx = fmt64 ? (DW_MSB - pos) : (W_MSB - pos);
    return idx[5:0];
  endfunction
endpackage

/* hdl/hist_decide_if.sv */
// Purpose: Carries one access and its flag decision between recorder and decider.
// Assumes: Decision is combinational within one cycle.
// Notes:   The recorder drives the access, the decider drives the needs.
`timescale 1ns/100ps
interface hist_decide_if;
  import rc_history_pkg::*;
  access_kind_t      kind;
  logic              blk;
  logic              ir;
  logic              dr;
  logic              hit;
  logic              cur_r;
  logic              cur_c;
  logic              prot_ok;
  logic              in_path;
  logic              precise_exc;
  logic              done_ok;
  logic [CTRL_W-1:0] ctrl;
  logic              need_r;
  logic              need_c;
  modport req (output kind, blk, ir, dr, hit, cur_r, cur_c, prot_ok, in_path, precise_exc,
               done_ok, ctrl, input need_r, need_c);
  modport dec (input kind, blk, ir, dr, hit, cur_r, cur_c, prot_ok, in_path, precise_exc,
               done_ok, ctrl, output need_r, need_c);
endinterface

/* hdl/hist_decide.sv */
// Purpose: Decides which history flags an access must set in the page table.
// Assumes: Flags given are those of the translation cache entry for the page.
// Notes:   Purely combinational; the recorder registers the result.
`timescale 1ns/100ps
module hist_decide
  import rc_history_pkg::*;
(
  hist_decide_if.dec d
);
  logic translated;
  logic have_r;
  logic ref_ok;
  logic c_ok;
  logic need_c_w;

  // Classifies the access and compares wanted flags with those already held.
  always_comb begin
    translated = !d.blk && ((d.kind == K_FETCH) ? d.ir : d.dr);
    have_r     = d.hit || d.cur_r;
    case (d.kind)
      K_TOUCH, K_TOUCH_ST: ref_ok = d.ctrl[CTRL_TOUCH];
      default:             ref_ok = 1'b1;
    endcase
    if (d.ctrl[CTRL_DEFER] && !d.done_ok) begin
      ref_ok = 1'b0;
    end
    case (d.kind)
      K_STORE:      c_ok = d.prot_ok && d.in_path && !d.precise_exc;
      K_CSTORE_NOP: c_ok = d.prot_ok && d.ctrl[CTRL_OPT_C];
      K_STR_ZERO:   c_ok = d.prot_ok && d.ctrl[CTRL_OPT_C];
      K_BLK_INVAL:  c_ok = d.ctrl[CTRL_OPT_C];
      default:      c_ok = 1'b0;
    endcase
    need_c_w = d.ctrl[CTRL_EN] && translated && c_ok && !d.cur_c;
    d.need_c = need_c_w;
    // A store that finds 00 sets both flags in the same update.
    d.need_r = d.ctrl[CTRL_EN] && translated && (ref_ok || need_c_w) && !have_r;
  end
endmodule

/* verification/pte_memory_model.sv */
// Purpose: Main memory model that takes page table flag updates and records the last one.
// Assumes: An update only sets the bits of its mask; nothing is cleared here.
// Notes:   Stalls at random from a fixed seed; keeps the last request taken.
`timescale 1ns/100ps
module pte_memory_model #(
  parameter int PA_W = 48
)(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            mem_req_valid,
  output logic                 mem_req_ready,
  input  wire logic [PA_W-1:0] mem_req_addr,
  input  wire logic [63:0]     mem_req_set_mask,
  input  wire logic [3:0]      mem_req_attr,
  input  wire logic            mem_req_real,
  output int                   taken_cnt,
  output logic [PA_W+68:0]     last_req
);
  logic [31:0] seed_r;

  // Takes an update at the edge where both sides agree, and stalls about half the time.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_req_ready <= 1'b0;
      taken_cnt     <= 0;
      seed_r        <= 32'h0000_5A17;
      last_req      <= '0;
    end else begin
      seed_r        <= {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
      mem_req_ready <= seed_r[0];
      if (mem_req_valid && mem_req_ready) begin
        taken_cnt <= taken_cnt + 1;
        last_req  <= {mem_req_addr, mem_req_set_mask, mem_req_attr, mem_req_real};
      end
    end
  end
endmodule

/* verification/test_page_history_recorder.sv */
// Purpose: Self-checking bench for the page history recorder.
// Assumes: The memory model takes each update whole, with random stalls.
// Notes:   Random accesses from a fixed xorshift seed, with directed corner cases.
`timescale 1ns/100ps
module test_page_history_recorder;
  import rc_history_pkg::*;
  localparam int PA_W = 48;
  // Fields: kind, block, ir, dr, hit, cur R, cur C, prot, path, exc, done.
  localparam logic [12:0] DIR_CASES [12] = '{
    13'b010_0_11_0_00_110_1, 13'b001_0_11_0_00_110_1, 13'b010_0_11_0_10_110_1,
    13'b001_0_11_0_10_110_1, 13'b010_0_11_0_11_110_1, 13'b010_1_11_0_00_110_1,
    13'b010_0_10_0_00_110_1, 13'b000_0_10_0_00_000_1, 13'b100_0_11_0_00_110_1,
    13'b010_0_11_1_10_110_1, 13'b010_0_11_0_00_010_1, 13'b111_0_11_0_00_110_1};
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic                acc_valid = 1'b0;
  logic [12:0]         acc_vec = '0;
  logic [PA_W-1:0]     acc_pte_addr = '0;
  logic                acc_ready, cache_set_r, cache_set_c;
  logic                mem_req_valid, mem_req_ready, mem_req_real;
  logic [PA_W-1:0]     mem_req_addr;
  logic [63:0]         mem_req_set_mask;
  logic [ATTR_W-1:0]   mem_req_attr;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]         s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]          s_axi_wstrb = 4'hF;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  int                  taken_cnt;
  logic [PA_W+68:0]    last_req;
  int                  failures = 0;
  int                  checks = 0;
  logic [31:0]         rnd = 32'h0000_72E6;
  logic [4:0]          ctrl_m = CTRL_RST;
  logic [4:0]          last_m = '0;

  // Free-running core clock.
  always #12.5 core_clk = ~core_clk;

  page_history_recorder #(.PA_W(PA_W)) u_page_history_recorder (
    .core_clk(core_clk), .rst(rst), .acc_valid(acc_valid), .acc_ready(acc_ready),
    .acc_kind(acc_vec[12:10]), .acc_block_xlate(acc_vec[9]),
    .instr_translate_enable(acc_vec[8]), .data_translate_enable(acc_vec[7]),
    .acc_cache_hit(acc_vec[6]), .acc_cur_r(acc_vec[5]), .acc_cur_c(acc_vec[4]),
    .acc_prot_ok(acc_vec[3]), .acc_in_path(acc_vec[2]), .acc_precise_exc(acc_vec[1]),
    .acc_done_ok(acc_vec[0]), .acc_pte_addr(acc_pte_addr), .cache_set_r(cache_set_r),
    .cache_set_c(cache_set_c), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_addr(mem_req_addr), .mem_req_set_mask(mem_req_set_mask),
    .mem_req_attr(mem_req_attr), .mem_req_real(mem_req_real),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  pte_memory_model #(.PA_W(PA_W)) u_pte_memory_model (
    .core_clk(core_clk), .rst(rst), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_req_set_mask(mem_req_set_mask), .mem_req_attr(mem_req_attr),
    .mem_req_real(mem_req_real), .taken_cnt(taken_cnt), .last_req(last_req));

  // Next value of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Flags an access must set, as {changed, referenced}.
  function automatic logic [1:0] expect_need(input logic [12:0] v, input logic [4:0] c);
    logic tr, cok, rok, nc;
    tr = !v[9] && ((v[12:10] == 3'd0) ? v[8] : v[7]);
    case (v[12:10])
      3'd2: cok = v[3] & v[2] & !v[1];
      3'd5, 3'd6: cok = v[3] & c[CTRL_OPT_C];
      3'd7: cok = c[CTRL_OPT_C];
      default: cok = 1'b0;
    endcase
    rok = (v[12:10] inside {3'd3, 3'd4}) ? c[CTRL_TOUCH] : 1'b1;
    if (c[CTRL_DEFER] && !v[0]) rok = 1'b0;
    nc = c[CTRL_EN] & tr & cok & !v[4];
    return {nc, c[CTRL_EN] & tr & (rok | nc) & !(v[6] | v[5])};
  endfunction

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One write; address and data are released each at its own take.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic awp, wp, at, wt, bv;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    awp = 1'b1;
    wp = 1'b1;
    while (awp || wp) begin
      #1;
      at = awp && s_axi_awready;
      wt = wp && s_axi_wready;
      @(posedge core_clk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      awp = awp && !at;
      wp = wp && !wt;
    end
    do begin
      #1;
      bv = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
    end while (!bv);
    s_axi_bready <= 1'b0;
  endtask

  // One read; rdata and rresp are taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic tk, rv;
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      tk = s_axi_arready;
      @(posedge core_clk);
    end while (!tk);
    s_axi_arvalid <= 1'b0;
    do begin
      #1;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
    end while (!rv);
    s_axi_rready <= 1'b0;
  endtask

  // Writes the control register and reads it back.
  task automatic set_ctrl(input logic [4:0] c);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(REG_CTRL, {27'h0, c}, r);
    ctrl_m = c;
    axi_rd(REG_CTRL, d, r);
    chk({r, d}, {RESP_OKAY, 27'h0, c}, "ctrl readback");
  endtask

  // Offers one access and checks the cache pulses and the table update.
  task automatic run_acc(input logic [12:0] v);
    logic [1:0] nd;
    logic [PA_W-1:0] a;
    int n0;
    nd = expect_need(v, ctrl_m);
    rnd = xs(rnd);
    a = {rnd[15:0], rnd};
    n0 = taken_cnt;
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_vec <= v;
    acc_pte_addr <= a;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
    chk(cache_set_r, nd[0], "cache R");
    chk(cache_set_c, nd[1], "cache C");
    chk(mem_req_valid, |nd, "update");
    chk(acc_ready, ~|nd, "ready");
    if (|nd) begin
      last_m = {v[12:10], nd};
      while (taken_cnt == n0) begin
        @(posedge core_clk);
        #1;
      end
      chk(last_req, {a, 55'h0, nd[0], nd[1], 7'h0, ATTR_PTE, 1'b1}, "request");
      chk(taken_cnt, n0 + 1, "one update");
      while (acc_ready !== 1'b1) begin
        @(posedge core_clk);
        #1;
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hung run short; the tests need well under this span.
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end

  // Main sequence: registers, directed cases, random traffic, counters.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [12:0] v;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    axi_rd(REG_CTRL, d, r);
    chk({r, d}, {RESP_OKAY, 27'h0, CTRL_RST}, "ctrl reset");
    axi_rd(8'h10, d, r);
    chk(r, RESP_DECERR, "unmapped");
    axi_wr(REG_COUNT, 32'hFFFF_FFFF, r);
    chk(r, RESP_OKAY, "read-only write resp");
    axi_wr(8'h10, 32'h0000_0000, r);
    chk(r, RESP_DECERR, "unmapped write");
    axi_rd(REG_COUNT, d, r);
    chk(d, 32'h0, "count read-only");
    $display("test registers done");
    foreach (DIR_CASES[i]) run_acc(DIR_CASES[i]);
    set_ctrl(5'h1F);
    run_acc(13'b111_0_11_0_00_000_1);
    run_acc(13'b110_0_11_0_00_100_1);
    run_acc(13'b001_0_11_0_00_110_0);
    $display("test directed done");
    for (int i = 0; i < 300; i++) begin
      rnd = xs(rnd);
      if (i % 40 == 0) set_ctrl(rnd[4:0] | {4'h0, rnd[7]});
      rnd = xs(rnd);
      v = rnd[12:0];
      if (v[5:4] == 2'b01) v[5] = 1'b1;
      run_acc(v);
    end
    $display("test random done");
    axi_rd(REG_COUNT, d, r);
    chk(d, 32'(taken_cnt), "update count");
    axi_rd(REG_STATUS, d, r);
    chk(d[0], 1'b0, "idle status");
    axi_rd(REG_LAST, d, r);
    chk({r, d}, {RESP_OKAY, 27'h0, last_m}, "last update");
    $display("test counters done");
    tally_and_finish;
  end
endmodule
